/* File: cwmba_map.svh */
`ifndef CWMBA_MAP_SVH
`define CWMBA_MAP_SVH

// instruction clocks, counted in processor clock cycles
`define CWMBA_CLK_ONE 3'h1
`define CWMBA_CLK_TWO 3'h2
`define CWMBA_CLK_PROG 3'h4
`define CWMBA_CLK_PROG_SEG 3'h5

// instruction lengths in bytes
`define CWMBA_LEN_1 3'h1
`define CWMBA_LEN_2 3'h2
`define CWMBA_LEN_3 3'h3
`define CWMBA_LEN_4 3'h4

// constant loads
`define CWMBA_PAIR_ONE 16'h0001
`define CWMBA_PAIR_ZERO 16'h0000
`define CWMBA_BYTE_ZERO 8'h00

// short direct window base, 20-bit space
`define CWMBA_SADDR_BASE 20'hFFE20

// reset values
`define CWMBA_RST_PAIR 16'h0000
`define CWMBA_RST_BYTE 8'h00
`define CWMBA_RST_ADDR 20'h00000
`define CWMBA_RST_CNT 3'h0

// positions in load_flags
`define CWMBA_FLAG_Z 2
`define CWMBA_FLAG_AC 1
`define CWMBA_FLAG_CY 0

// reg_sel encodings
`define CWMBA_SEL_0 2'h0
`define CWMBA_SEL_1 2'h1
`define CWMBA_SEL_2 2'h2

`endif

/* File: cwmba_pkg.sv */
`default_nettype none

package cwmba_pkg;

  typedef enum logic [3:0] {
    CWMBA_OP_NOP,
    CWMBA_OP_WORD_MOVE_STORE_SEG,
    CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX,
    CWMBA_OP_SET_PAIR_TO_ONE,
    CWMBA_OP_CLEAR_PAIR,
    CWMBA_OP_ADD_SADDR_IMM,
    CWMBA_OP_ADD_A_SEG_DISP,
    CWMBA_OP_ADD_WITH_CARRY_IN_A_IMM,
    CWMBA_OP_ADD_WITH_CARRY_IN_R_A,
    CWMBA_OP_SUB_SADDR_IMM,
    CWMBA_OP_SUB_A_PTR_IDX,
    CWMBA_OP_SUBTRACT_WITH_BORROW_A_IMM,
    CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX,
    CWMBA_OP_AND_SADDR_IMM,
    CWMBA_OP_AND_A_PTR,
    CWMBA_OP_AND_A_SEG_DISP
  } cwmba_op_t;

endpackage : cwmba_pkg

`default_nettype wire

/* File: cwmba_exec.sv */
// Overview of operation
// - one instruction clock is one sys_clk cycle, the selected processor clock
// - program memory reads take 4 clocks, or 5 for segment-extended forms
// - segment store writes word pair to segment, pointer plus byte; 3 bytes, 2 clocks
// - segment indexed word load: segment, index plus word; 4 bytes, 2 or 5 clocks
// - set-pair-to-one loads 0001H into either pair; 1 byte, 1 clock, flags kept
// - clear-pair loads 0000H into either pair; 1 byte, 1 clock, flags kept
// - add immediate into short direct byte; 3 bytes, 2 clocks, Z AC CY updated
// - segment add of pointer plus displacement byte; 3 bytes, 2 or 5 clocks
// - add-with-carry immediate into accumulator; 2 bytes, 1 clock, flags updated
// - add-with-carry of accumulator into X, B or C; 2 bytes, 1 clock
// - subtract immediate from short direct byte, carry is borrow; 3 bytes, 2 clocks
// - subtract pointer plus B or C byte; 2 bytes, 1 or 4 clocks
// - subtract-with-borrow immediate from accumulator; 2 bytes, 1 clock
// - segment subtract-with-borrow, pointer plus B or C; 3 bytes, 2 or 5 clocks
// - AND immediate into short direct byte; 3 bytes, 2 clocks, only Z
// - AND with pointer byte; 1 byte, 1 or 4 clocks, only Z
// - segment AND with displacement; 3 bytes, 2 or 5 clocks
`include "cwmba_map.svh"

`default_nettype none

module cwmba_exec
  import cwmba_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire cwmba_pkg::cwmba_op_t op,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] imm8,
  input wire logic [15:0] word16,
  input wire logic [7:0] saddr8,
  input wire logic [15:0] pointer_pair,
  input wire logic [3:0] extended_segment_register,
  input wire logic mem_in_prog,
  input wire logic [15:0] mem_rdata,
  input wire logic load_en,
  input wire logic [15:0] load_ax,
  input wire logic [15:0] load_bc,
  input wire logic [7:0] load_x,
  input wire logic [2:0] load_flags,
  output logic busy,
  output logic done,
  output logic [2:0] instr_bytes,
  output logic [2:0] instr_clocks,
  output logic [15:0] word_accumulator_pair,
  output logic [15:0] second_pair,
  output logic [7:0] general_x,
  output logic zero_flag,
  output logic half_carry_flag,
  output logic carry_flag,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_word,
  output logic [19:0] mem_addr,
  output logic [15:0] mem_wdata
);
  import cwmba_pkg::*;

  // operands held for the whole instruction
  cwmba_op_t op_q;
  logic [1:0] sel_q;
  logic [7:0] imm_q;
  logic [2:0] cnt;

  logic [2:0] next_clocks;
  logic [2:0] next_bytes;
  logic next_read;
  logic next_seg;
  logic [19:0] next_addr;
  logic [15:0] next_ax;
  logic [15:0] next_bc;
  logic [7:0] next_x;
  logic next_z;
  logic next_h;
  logic next_c;
  logic next_wr;
  logic [7:0] next_wbyte;
  logic [9:0] alu;
  logic [7:0] idx;
  logic [7:0] rsrc;
  logic take;
  logic finish;

  assign take = start && !busy;
  assign finish = busy && (cnt == `CWMBA_RST_CNT);

  // returns {carry, half, result}
  function automatic logic [9:0] alu8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin, input logic sub);
    logic [4:0] lo;
    logic [8:0] full;
    lo = 5'h00;
    full = 9'h000;
    if (sub)
    begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    end
    else
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
    alu8 = {full[8], lo[4], full[7:0]};
  endfunction : alu8

  // decode at issue: length, clocks, read target address
  always_comb
  begin
    next_bytes = `CWMBA_LEN_1;
    next_read = 1'b0;
    next_seg = 1'b0;
    next_addr = `CWMBA_RST_ADDR;
    idx = `CWMBA_BYTE_ZERO;
    case (op)
      CWMBA_OP_WORD_MOVE_STORE_SEG:
      begin
        next_bytes = `CWMBA_LEN_3;
        next_seg = 1'b1;
        next_addr = {extended_segment_register, 16'(pointer_pair + {8'h00, imm8})};
      end
      CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX:
      begin
        next_bytes = `CWMBA_LEN_4;
        next_read = 1'b1;
        next_seg = 1'b1;
        case (reg_sel)
          `CWMBA_SEL_0: next_addr = {extended_segment_register,
                                     16'(word16 + {8'h00, second_pair[15:8]})};
          `CWMBA_SEL_1: next_addr = {extended_segment_register,
                                     16'(word16 + {8'h00, second_pair[7:0]})};
          default: next_addr = {extended_segment_register, 16'(word16 + second_pair)};
        endcase
      end
      CWMBA_OP_SET_PAIR_TO_ONE,
      CWMBA_OP_CLEAR_PAIR:
      begin
        next_bytes = `CWMBA_LEN_1;
      end
      CWMBA_OP_ADD_SADDR_IMM,
      CWMBA_OP_SUB_SADDR_IMM,
      CWMBA_OP_AND_SADDR_IMM:
      begin
        next_bytes = `CWMBA_LEN_3;
        next_seg = 1'b1;
        next_addr = 20'(`CWMBA_SADDR_BASE + {12'h000, saddr8});
      end
      CWMBA_OP_ADD_A_SEG_DISP,
      CWMBA_OP_AND_A_SEG_DISP:
      begin
        next_bytes = `CWMBA_LEN_3;
        next_read = 1'b1;
        next_seg = 1'b1;
        next_addr = {extended_segment_register, 16'(pointer_pair + {8'h00, imm8})};
      end
      CWMBA_OP_ADD_WITH_CARRY_IN_A_IMM,
      CWMBA_OP_ADD_WITH_CARRY_IN_R_A,
      CWMBA_OP_SUBTRACT_WITH_BORROW_A_IMM:
      begin
        next_bytes = `CWMBA_LEN_2;
      end
      CWMBA_OP_SUB_A_PTR_IDX:
      begin
        next_bytes = `CWMBA_LEN_2;
        next_read = 1'b1;
        idx = (reg_sel == `CWMBA_SEL_1) ? second_pair[7:0] : second_pair[15:8];
        next_addr = {4'h0, 16'(pointer_pair + {8'h00, idx})};
      end
      CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX:
      begin
        next_bytes = `CWMBA_LEN_3;
        next_read = 1'b1;
        next_seg = 1'b1;
        idx = (reg_sel == `CWMBA_SEL_1) ? second_pair[7:0] : second_pair[15:8];
        next_addr = {extended_segment_register, 16'(pointer_pair + {8'h00, idx})};
      end
      CWMBA_OP_AND_A_PTR:
      begin
        next_bytes = `CWMBA_LEN_1;
        next_read = 1'b1;
        next_addr = {4'h0, pointer_pair};
      end
      default:
      begin
        next_bytes = `CWMBA_LEN_1;
      end
    endcase
    // stores and saddr forms never target program memory, so only reads stretch
    if (next_read && mem_in_prog)
    begin
      next_clocks = next_seg ? `CWMBA_CLK_PROG_SEG : `CWMBA_CLK_PROG;
    end
    else
    begin
      next_clocks = next_seg ? `CWMBA_CLK_TWO : `CWMBA_CLK_ONE;
    end
  end

  // issue and countdown in processor clocks
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      cnt <= `CWMBA_RST_CNT;
      instr_bytes <= `CWMBA_LEN_1;
      instr_clocks <= `CWMBA_CLK_ONE;
    end
    else if (take)
    begin
      busy <= 1'b1;
      cnt <= 3'(next_clocks - `CWMBA_CLK_ONE);
      instr_bytes <= next_bytes;
      instr_clocks <= next_clocks;
    end
    else if (finish)
    begin
      busy <= 1'b0;
    end
    else if (busy)
    begin
      cnt <= 3'(cnt - `CWMBA_CLK_ONE);
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      op_q <= CWMBA_OP_NOP;
      sel_q <= `CWMBA_SEL_0;
      imm_q <= `CWMBA_RST_BYTE;
    end
    else if (take)
    begin
      op_q <= op;
      sel_q <= reg_sel;
      imm_q <= imm8;
    end
  end

  // execute at the last clock of the instruction
  always_comb
  begin
    next_ax = word_accumulator_pair;
    next_bc = second_pair;
    next_x = general_x;
    next_z = zero_flag;
    next_h = half_carry_flag;
    next_c = carry_flag;
    next_wr = 1'b0;
    next_wbyte = `CWMBA_BYTE_ZERO;
    alu = 10'h000;
    rsrc = general_x;
    case (op_q)
      CWMBA_OP_WORD_MOVE_STORE_SEG:
      begin
        next_wr = 1'b1;
      end
      CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX:
      begin
        next_ax = mem_rdata;
      end
      CWMBA_OP_SET_PAIR_TO_ONE:
      begin
        if (sel_q == `CWMBA_SEL_0)
          next_ax = `CWMBA_PAIR_ONE;
        else
          next_bc = `CWMBA_PAIR_ONE;
      end
      CWMBA_OP_CLEAR_PAIR:
      begin
        if (sel_q == `CWMBA_SEL_0)
          next_ax = `CWMBA_PAIR_ZERO;
        else
          next_bc = `CWMBA_PAIR_ZERO;
      end
      CWMBA_OP_ADD_SADDR_IMM,
      CWMBA_OP_SUB_SADDR_IMM:
      begin
        alu = alu8(mem_rdata[7:0], imm_q, 1'b0, op_q == CWMBA_OP_SUB_SADDR_IMM);
        next_wr = 1'b1;
        next_wbyte = alu[7:0];
        next_z = (alu[7:0] == `CWMBA_BYTE_ZERO);
        next_h = alu[8];
        next_c = alu[9];
      end
      CWMBA_OP_ADD_A_SEG_DISP:
      begin
        alu = alu8(word_accumulator_pair[15:8], mem_rdata[7:0], 1'b0, 1'b0);
        next_ax = {alu[7:0], word_accumulator_pair[7:0]};
        next_z = (alu[7:0] == `CWMBA_BYTE_ZERO);
        next_h = alu[8];
        next_c = alu[9];
      end
      CWMBA_OP_ADD_WITH_CARRY_IN_A_IMM,
      CWMBA_OP_SUBTRACT_WITH_BORROW_A_IMM:
      begin
        alu = alu8(word_accumulator_pair[15:8], imm_q, carry_flag,
                   op_q == CWMBA_OP_SUBTRACT_WITH_BORROW_A_IMM);
        next_ax = {alu[7:0], word_accumulator_pair[7:0]};
        next_z = (alu[7:0] == `CWMBA_BYTE_ZERO);
        next_h = alu[8];
        next_c = alu[9];
      end
      CWMBA_OP_ADD_WITH_CARRY_IN_R_A:
      begin
        case (sel_q)
          `CWMBA_SEL_1: rsrc = second_pair[15:8];
          `CWMBA_SEL_2: rsrc = second_pair[7:0];
          default: rsrc = general_x;
        endcase
        alu = alu8(rsrc, word_accumulator_pair[15:8], carry_flag, 1'b0);
        next_z = (alu[7:0] == `CWMBA_BYTE_ZERO);
        next_h = alu[8];
        next_c = alu[9];
        case (sel_q)
          `CWMBA_SEL_1: next_bc = {alu[7:0], second_pair[7:0]};
          `CWMBA_SEL_2: next_bc = {second_pair[15:8], alu[7:0]};
          default: next_x = alu[7:0];
        endcase
      end
      CWMBA_OP_SUB_A_PTR_IDX,
      CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX:
      begin
        alu = alu8(word_accumulator_pair[15:8], mem_rdata[7:0],
                   (op_q == CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX) && carry_flag,
                   1'b1);
        next_ax = {alu[7:0], word_accumulator_pair[7:0]};
        next_z = (alu[7:0] == `CWMBA_BYTE_ZERO);
        next_h = alu[8];
        next_c = alu[9];
      end
      CWMBA_OP_AND_SADDR_IMM:
      begin
        next_wr = 1'b1;
        next_wbyte = mem_rdata[7:0] & imm_q;
        next_z = (next_wbyte == `CWMBA_BYTE_ZERO);
      end
      CWMBA_OP_AND_A_PTR,
      CWMBA_OP_AND_A_SEG_DISP:
      begin
        // logical forms leave half-carry and carry alone
        next_ax = {word_accumulator_pair[15:8] & mem_rdata[7:0],
                   word_accumulator_pair[7:0]};
        next_z = (next_ax[15:8] == `CWMBA_BYTE_ZERO);
      end
      default:
      begin
        next_wr = 1'b0;
      end
    endcase
  end

  // register file: commit wins over an external load in the same cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      word_accumulator_pair <= `CWMBA_RST_PAIR;
      second_pair <= `CWMBA_RST_PAIR;
      general_x <= `CWMBA_RST_BYTE;
    end
    else if (finish)
    begin
      word_accumulator_pair <= next_ax;
      second_pair <= next_bc;
      general_x <= next_x;
    end
    else if (load_en && !busy)
    begin
      word_accumulator_pair <= load_ax;
      second_pair <= load_bc;
      general_x <= load_x;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      zero_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      carry_flag <= 1'b0;
    end
    else if (finish)
    begin
      zero_flag <= next_z;
      half_carry_flag <= next_h;
      carry_flag <= next_c;
    end
    else if (load_en && !busy)
    begin
      zero_flag <= load_flags[`CWMBA_FLAG_Z];
      half_carry_flag <= load_flags[`CWMBA_FLAG_AC];
      carry_flag <= load_flags[`CWMBA_FLAG_CY];
    end
  end

  // memory side: read strobe after issue, write strobe after the last clock
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_word <= 1'b0;
      mem_addr <= `CWMBA_RST_ADDR;
      mem_wdata <= `CWMBA_RST_PAIR;
      done <= 1'b0;
    end
    else
    begin
      done <= finish;
      mem_rd <= take && (next_read || op == CWMBA_OP_ADD_SADDR_IMM
                || op == CWMBA_OP_SUB_SADDR_IMM || op == CWMBA_OP_AND_SADDR_IMM);
      mem_wr <= finish && next_wr;
      if (take)
      begin
        mem_addr <= next_addr;
        mem_word <= (op == CWMBA_OP_WORD_MOVE_STORE_SEG)
                    || (op == CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX);
      end
      if (finish)
      begin
        mem_wdata <= (op_q == CWMBA_OP_WORD_MOVE_STORE_SEG) ? word_accumulator_pair
                     : {8'h00, next_wbyte};
      end
    end
  end

endmodule : cwmba_exec

`default_nettype wire

/* File: cwmba_exec_assertions.sv */
`default_nettype none

module cwmba_exec_assertions
  import cwmba_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire cwmba_pkg::cwmba_op_t op,
  input wire logic mem_in_prog,
  input wire logic busy,
  input wire logic done,
  input wire logic [2:0] instr_clocks,
  input wire logic [15:0] word_accumulator_pair,
  input wire logic zero_flag,
  input wire logic half_carry_flag,
  input wire logic carry_flag,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mem_word,
  input wire logic [15:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  cwmba_op_t hop;
  logic hpr;
  logic [2:0] cnt;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // opcode kept from issue, the port may move on before done
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      hop <= CWMBA_OP_NOP;
      hpr <= 1'h0;
    end
    else if (start && !busy)
    begin
      hop <= op;
      hpr <= mem_in_prog;
    end
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      cnt <= 3'h0;
    else
      cnt <= busy ? cnt + 3'h1 : 3'h0;
  a_busy_span: assert property ($fell(busy) |-> cnt == instr_clocks && done)
    else $error("busy length differs from clock count");
  a_read_pulse: assert property (mem_rd |-> $rose(busy) ##1 !mem_rd)
    else $error("read strobe misplaced");
  a_write_done: assert property (mem_wr |-> done)
    else $error("write outside done cycle");
  a_seg_long: assert property ($rose(busy) && hpr && hop inside {CWMBA_OP_ADD_A_SEG_DISP,
    CWMBA_OP_AND_A_SEG_DISP, CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX,
    CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX} |-> instr_clocks == 3'h5)
    else $error("segment read from program memory not 5 clocks");
  a_ptr_long: assert property ($rose(busy) && hop inside {CWMBA_OP_AND_A_PTR,
    CWMBA_OP_SUB_A_PTR_IDX} |-> instr_clocks == (hpr ? 3'h4 : 3'h1))
    else $error("pointer read clock count wrong");
  a_pair_flags: assert property (done && hop inside {CWMBA_OP_SET_PAIR_TO_ONE,
    CWMBA_OP_CLEAR_PAIR} |-> $stable({zero_flag, half_carry_flag, carry_flag}))
    else $error("pair load changed flags");
  a_and_keeps: assert property (done && hop inside {CWMBA_OP_AND_SADDR_IMM, CWMBA_OP_AND_A_PTR,
    CWMBA_OP_AND_A_SEG_DISP} |-> $stable({half_carry_flag, carry_flag}))
    else $error("logical op changed carries");
  a_zero_mem: assert property (mem_wr && hop != CWMBA_OP_WORD_MOVE_STORE_SEG
    |-> zero_flag == (mem_wdata[7:0] == 8'h00))
    else $error("zero flag disagrees with stored byte");
  a_store_word: assert property (mem_wr && hop == CWMBA_OP_WORD_MOVE_STORE_SEG
    |-> mem_word && mem_wdata == word_accumulator_pair)
    else $error("word store data wrong");
endmodule : cwmba_exec_assertions

bind cwmba_exec cwmba_exec_assertions u_chk (.sys_clk, .reset, .start, .op, .mem_in_prog,
  .busy, .done, .instr_clocks, .word_accumulator_pair, .zero_flag, .half_carry_flag,
  .carry_flag, .mem_rd, .mem_wr, .mem_word, .mem_wdata);

`default_nettype wire

/* File: cwmba_mem.sv */
`default_nettype none

module cwmba_mem (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic mem_rd,
  input wire logic done,
  input wire logic [19:0] mem_addr,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend;
  logic [15:0] last;
  // data held from the strobe until done, long reads included
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      pend <= 1'h0;
    else
      pend <= mem_rd | (pend & ~done);
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      last <= 16'h0000;
    else
      last <= mem_rdata;
  // idle bus toggles so a stale read cannot pass
  assign mem_rdata = (mem_rd | pend) ? {mem_addr[7:0] ^ 8'hA5, mem_addr[7:0] ^ 8'h5A} : ~last;
endmodule : cwmba_mem

`default_nettype wire

/* File: tb_top.sv */
`default_nettype none

module tb_top
  import cwmba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, reset = 1'h1, start = 1'h0, mem_in_prog = 1'h0, load_en = 1'h0;
  cwmba_op_t op = CWMBA_OP_NOP;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] imm8 = 8'h00, saddr8 = 8'h00, load_x = 8'h00, general_x;
  logic [15:0] word16 = 16'h0, pointer_pair = 16'h0, load_ax = 16'h0, load_bc = 16'h0;
  logic [3:0] extended_segment_register = 4'h0;
  logic [2:0] load_flags = 3'h0, instr_bytes, instr_clocks;
  logic [15:0] mem_rdata, word_accumulator_pair, second_pair, mem_wdata;
  logic busy, done, zero_flag, half_carry_flag, carry_flag, mem_rd, mem_wr, mem_word;
  logic [19:0] mem_addr;
  int n_mismatch = 0, n_checks = 0;
  cwmba_exec u_dut (.sys_clk, .reset, .start, .op, .reg_sel, .imm8, .word16, .saddr8,
    .pointer_pair, .extended_segment_register, .mem_in_prog, .mem_rdata, .load_en, .load_ax,
    .load_bc, .load_x, .load_flags, .busy, .done, .instr_bytes, .instr_clocks,
    .word_accumulator_pair, .second_pair, .general_x, .zero_flag, .half_carry_flag,
    .carry_flag, .mem_rd, .mem_wr, .mem_word, .mem_addr, .mem_wdata);
  cwmba_mem u_mem (.sys_clk, .reset, .mem_rd, .done, .mem_addr, .mem_rdata);
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [19:0] e, input logic [19:0] g, input string s);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic ld(input logic [15:0] ax, bc, input logic [2:0] f, input logic [15:0] hl,
    input logic [3:0] es, input logic [7:0] sa, input logic [15:0] w);
    @(posedge sys_clk);
    load_en <= 1'h1;
    load_ax <= ax;
    load_bc <= bc;
    load_flags <= f;
    pointer_pair <= hl;
    extended_segment_register <= es;
    saddr8 <= sa;
    word16 <= w;
    @(posedge sys_clk);
    load_en <= 1'h0;
  endtask : ld
  // issues one op, counts busy cycles, checks length, clocks and flags at done
  task automatic ex(input cwmba_op_t o, input logic [1:0] s, input logic [7:0] i,
    input logic p, input logic [2:0] eb, ec, ef);
    logic [2:0] n;
    n = 3'h0;
    @(posedge sys_clk);
    start <= 1'h1;
    op <= o;
    reg_sel <= s;
    imm8 <= i;
    mem_in_prog <= p;
    repeat (8)
    begin
      @(posedge sys_clk);
      start <= 1'h0;
      #1;
      if (done === 1'h1)
        break;
      if (busy === 1'h1)
        n++;
    end
    if (done !== 1'h1)
    begin
      chk(20'h00001, 20'(done), "done within limit");
      wrap_up();
    end
    else
    begin
      chk(20'(ec), 20'(n), "busy cycles");
      chk(20'({eb, ec}), 20'({instr_bytes, instr_clocks}), "bytes and clocks");
      chk(20'(ef), 20'({zero_flag, half_carry_flag, carry_flag}), "flags");
    end
  endtask : ex
  task automatic t_pair;
    ld(16'hAAAA, 16'h5555, 3'h7, 16'h0, 4'h0, 8'h00, 16'h0);
    ex(CWMBA_OP_SET_PAIR_TO_ONE, 2'h0, 8'h00, 1'h0, 3'h1, 3'h1, 3'h7);
    chk(20'h00001, 20'(word_accumulator_pair), "ax");
    ex(CWMBA_OP_SET_PAIR_TO_ONE, 2'h1, 8'h00, 1'h0, 3'h1, 3'h1, 3'h7);
    chk(20'h00001, 20'(second_pair), "bc");
    ex(CWMBA_OP_CLEAR_PAIR, 2'h0, 8'h00, 1'h0, 3'h1, 3'h1, 3'h7);
    chk(20'h00000, 20'(word_accumulator_pair), "ax clear");
    ex(CWMBA_OP_CLEAR_PAIR, 2'h1, 8'h00, 1'h0, 3'h1, 3'h1, 3'h7);
    chk(20'h00000, 20'(second_pair), "bc clear");
  endtask : t_pair
  task automatic t_word;
    ld(16'h1234, 16'h0040, 3'h0, 16'h1000, 4'h3, 8'h00, 16'h0100);
    ex(CWMBA_OP_WORD_MOVE_STORE_SEG, 2'h0, 8'h20, 1'h0, 3'h3, 3'h2, 3'h0);
    chk(20'h31020, mem_addr, "store addr");
    chk(20'h11234, 20'({mem_wr, mem_wdata}), "store data");
    @(posedge sys_clk);
    extended_segment_register <= 4'h2;
    ex(CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX, 2'h0, 8'h00, 1'h0, 3'h4, 3'h2, 3'h0);
    chk(20'h20100, mem_addr, "load addr b");
    ex(CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX, 2'h1, 8'h00, 1'h0, 3'h4, 3'h2, 3'h0);
    chk(20'h20140, mem_addr, "load addr");
    ex(CWMBA_OP_WORD_MOVE_LOAD_SEG_IDX, 2'h1, 8'h00, 1'h1, 3'h4, 3'h5, 3'h0);
    chk(20'h0E51A, 20'(word_accumulator_pair), "load ax");
  endtask : t_word
  task automatic t_add;
    ld(16'hA600, 16'h0, 3'h0, 16'h00F0, 4'h5, 8'h10, 16'h0);
    ex(CWMBA_OP_ADD_SADDR_IMM, 2'h0, 8'h96, 1'h0, 3'h3, 3'h2, 3'h7);
    chk(20'hFFE30, mem_addr, "add addr");
    chk(20'h00100, 20'({mem_wr, mem_wdata[7:0]}), "add sum");
    ex(CWMBA_OP_ADD_A_SEG_DISP, 2'h0, 8'h10, 1'h1, 3'h3, 3'h5, 3'h7);
    chk(20'h50100, mem_addr, "seg addr");
    chk(20'h00000, 20'(word_accumulator_pair[15:8]), "seg sum");
    ld(16'h0F00, 16'h8000, 3'h1, 16'h0, 4'h0, 8'h00, 16'h0);
    ex(CWMBA_OP_ADD_WITH_CARRY_IN_A_IMM, 2'h0, 8'h00, 1'h0, 3'h2, 3'h1, 3'h2);
    chk(20'h00010, 20'(word_accumulator_pair[15:8]), "add_with_carry_in a");
    ld(16'h8000, 16'h8000, 3'h1, 16'h0, 4'h0, 8'h00, 16'h0);
    ex(CWMBA_OP_ADD_WITH_CARRY_IN_R_A, 2'h1, 8'h00, 1'h0, 3'h2, 3'h1, 3'h1);
    chk(20'h00100, 20'(second_pair), "add_with_carry_in b");
    ex(CWMBA_OP_ADD_WITH_CARRY_IN_R_A, 2'h0, 8'h00, 1'h0, 3'h2, 3'h1, 3'h0);
    chk(20'h00081, 20'(general_x), "add_with_carry_in x");
  endtask : t_add
  task automatic t_sub;
    ld(16'h5200, 16'h0300, 3'h0, 16'h0005, 4'h0, 8'h00, 16'h0);
    ex(CWMBA_OP_SUB_SADDR_IMM, 2'h0, 8'h7B, 1'h0, 3'h3, 3'h2, 3'h3);
    chk(20'h001FF, 20'({mem_wr, mem_wdata[7:0]}), "sub diff");
    ex(CWMBA_OP_SUB_A_PTR_IDX, 2'h0, 8'h00, 1'h0, 3'h2, 3'h1, 3'h4);
    chk(20'h00008, mem_addr, "sub addr");
    ex(CWMBA_OP_SUB_A_PTR_IDX, 2'h0, 8'h00, 1'h1, 3'h2, 3'h4, 3'h3);
    chk(20'h000AE, 20'(word_accumulator_pair[15:8]), "sub a");
    ld(16'h0000, 16'h0002, 3'h1, 16'h0010, 4'h1, 8'h00, 16'h0);
    ex(CWMBA_OP_SUBTRACT_WITH_BORROW_A_IMM, 2'h0, 8'h00, 1'h0, 3'h2, 3'h1, 3'h3);
    ex(CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX, 2'h1, 8'h00, 1'h0, 3'h3, 3'h2, 3'h0);
    chk(20'h100B6, {mem_addr[19:8], word_accumulator_pair[15:8]}, "subtract_with_borrow");
    ex(CWMBA_OP_SUBTRACT_WITH_BORROW_SEG_IDX, 2'h1, 8'h00, 1'h1, 3'h3, 3'h5, 3'h2);
    chk(20'h0006E, 20'(word_accumulator_pair[15:8]), "subtract_with_borrow prog");
  endtask : t_sub
  task automatic t_and;
    ld(16'h9600, 16'h0, 3'h3, 16'h0033, 4'h4, 8'h05, 16'h0);
    ex(CWMBA_OP_AND_SADDR_IMM, 2'h0, 8'h80, 1'h0, 3'h3, 3'h2, 3'h7);
    chk(20'hFFE25, mem_addr, "and addr");
    ex(CWMBA_OP_AND_A_PTR, 2'h0, 8'h00, 1'h1, 3'h1, 3'h4, 3'h7);
    ex(CWMBA_OP_AND_A_PTR, 2'h0, 8'h00, 1'h0, 3'h1, 3'h1, 3'h7);
    ld(16'hFF00, 16'h0, 3'h0, 16'h0100, 4'h4, 8'h00, 16'h0);
    ex(CWMBA_OP_AND_A_SEG_DISP, 2'h0, 8'h01, 1'h1, 3'h3, 3'h5, 3'h0);
    chk(20'h4015B, {mem_addr[19:8], word_accumulator_pair[15:8]}, "and seg");
  endtask : t_and
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    #1;
    chk(20'h00009, 20'({instr_bytes, instr_clocks}), "reset length");
    t_pair();
    t_word();
    t_add();
    t_sub();
    t_and();
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
